// ### lxd_exec.sv
// Execution datapath for exclusive-OR, exclusive-NOR and modulo-division write-back
// Contract
// RQ1: Modulo division writes the upper 24-bit result, the quotient, into the first operand accumulator.
// RQ2: Modulo division writes the remainder into the second operand accumulator, replacing it.
// RQ3: Exclusive-OR of two accumulators goes to the first operand, equal bits giving 0 and differing bits 1.
// RQ4: Exclusive-OR also takes an immediate second operand and stores the result in the first accumulator.
// RQ5: Exclusive-NOR gives equal bits 1 and differing bits 0, stored in the first operand.
// RQ6: The first operand is one of x, y, z, r; the second is an accumulator or a 24-bit immediate.
// RQ7: Exclusive-OR and exclusive-NOR change only sign and nonzero flags, never carry or overflow.
// RQ8: Both logic operations are 2 bytes long with an accumulator operand and 5 bytes with an immediate.
// RQ9: Both logic operations take 3 cycles with an accumulator operand and 6 cycles with an immediate.
// RQ10: Sign flag is set for a negative 24-bit result and nonzero flag for a result other than zero.
// RQ11: In exclusive-OR and exclusive-NOR a second operand accumulator keeps its value; only the first operand and the two flags change.
`timescale 1ns/10ps
`default_nettype none

module lxd_exec #(
    parameter int unsigned DATA_W = lxd_pkg::DATA_W    // Accumulator width
) (
    input  wire logic              clk,           // Core clock, 40 MHz
    input  wire logic              sys_rst,       // Asynchronous reset, active high
    input  wire logic              op_valid,      // Decoder offers an operation
    output logic                   op_ready,      // Datapath idle, operation taken
    input  wire logic [1:0]        op_code,       // Operation code
    input  wire logic [1:0]        op_dst_sel,    // First operand accumulator
    input  wire logic [1:0]        op_src_sel,    // Second operand accumulator
    input  wire logic              op_src_imm,    // Second operand is immediate
    input  wire logic [DATA_W-1:0] op_imm,        // Immediate value
    output logic [2:0]             instr_len_q,   // Encoding length of last taken legal op
    output logic                   op_done,       // Last cycle of the operation
    output logic                   div_start,     // Start pulse to divider
    output logic [DATA_W-1:0]      div_dividend,  // Latched first operand
    output logic [DATA_W-1:0]      div_divisor,   // Latched second operand
    input  wire logic              div_done,      // Divider result valid
    input  wire logic [DATA_W-1:0] div_quot,      // Divider quotient
    input  wire logic [DATA_W-1:0] div_rem,       // Divider remainder
    input  wire logic              acc_wr_en,     // Write from other units, idle only
    input  wire logic [1:0]        acc_wr_sel,    // Accumulator to write
    input  wire logic [DATA_W-1:0] acc_wr_data,   // Data to write
    input  wire logic              flag_wr_en,    // Carry/overflow load, idle only
    input  wire logic              flag_carry_in, // New carry
    input  wire logic              flag_ovf_in,   // New overflow
    output logic [DATA_W-1:0]      acc_x_q,       // Accumulator x
    output logic [DATA_W-1:0]      acc_y_q,       // Accumulator y
    output logic [DATA_W-1:0]      acc_z_q,       // Accumulator z
    output logic [DATA_W-1:0]      acc_r_q,       // Accumulator r
    output logic                   flag_sign_q,   // Sign flag
    output logic                   flag_nz_q,     // Nonzero flag
    output logic                   flag_carry_q,  // Carry flag
    output logic                   flag_ovf_q     // Overflow flag
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DATA_W != lxd_pkg::DATA_W) begin : g_bad_width
        $error("lxd_exec supports only the documented accumulator width");
    end

    // ------------------------------------------------------------
    // State and operand latches
    // ------------------------------------------------------------
    lxd_pkg::lxd_state_t state_q;
    lxd_pkg::lxd_state_t state_d;
    logic [DATA_W-1:0]   acc_q [lxd_pkg::ACC_NUM];
    logic [DATA_W-1:0]   opa_q;
    logic [DATA_W-1:0]   opb_q;
    logic [1:0]          dst_q;
    logic [1:0]          src_q;
    logic                xnor_q;
    logic [2:0]          cnt_q;
    logic                start_q;
    logic                take;
    logic                legal;
    logic                logic_wr;
    logic                div_wr;
    logic [DATA_W-1:0]   logic_res;
    logic [DATA_W-1:0]   flag_src;

    // Operation acceptance; code 2'b11 is taken but does nothing
    assign op_ready = (state_q == lxd_pkg::LXD_ST_IDLE);
    assign take     = op_valid && op_ready;
    assign legal    = (op_code != 2'b11);

    // Write-back moments
    assign logic_wr = (state_q == lxd_pkg::LXD_ST_LOGIC) && (cnt_q == lxd_pkg::CNT_LAST);
    assign div_wr   = (state_q == lxd_pkg::LXD_ST_DIVW) && div_done;
    assign op_done  = logic_wr || div_wr;

    // Bitwise result from latched operands
    assign logic_res = xnor_q ? ~(opa_q ^ opb_q) : (opa_q ^ opb_q); // [RQ3] [RQ5]

    // Divider hand-off
    assign div_start    = start_q;
    assign div_dividend = opa_q;
    assign div_divisor  = opb_q;

    // Accumulator views
    assign acc_x_q = acc_q[lxd_pkg::ACC_X];
    assign acc_y_q = acc_q[lxd_pkg::ACC_Y];
    assign acc_z_q = acc_q[lxd_pkg::ACC_Z];
    assign acc_r_q = acc_q[lxd_pkg::ACC_R];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            lxd_pkg::LXD_ST_IDLE: begin
                if (take && legal) begin
                    if (op_code == lxd_pkg::LXD_OP_DIVMOD) begin
                        state_d = lxd_pkg::LXD_ST_DIVW;
                    end else begin
                        state_d = lxd_pkg::LXD_ST_LOGIC;
                    end
                end
            end
            lxd_pkg::LXD_ST_LOGIC: begin
                if (logic_wr) begin
                    state_d = lxd_pkg::LXD_ST_IDLE;
                end
            end
            lxd_pkg::LXD_ST_DIVW: begin
                if (div_wr) begin
                    state_d = lxd_pkg::LXD_ST_IDLE;
                end
            end
            default: begin
                state_d = lxd_pkg::LXD_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= lxd_pkg::LXD_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Cycle counter: taken cycle plus remaining cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (take && legal) begin
            cnt_q <= (op_src_imm ? lxd_pkg::CYC_IMM : lxd_pkg::CYC_ACC) - 3'h1; // [RQ9]
        end else if (state_q == lxd_pkg::LXD_ST_LOGIC) begin
            cnt_q <= cnt_q - 3'h1; // [RQ9]
        end
    end

    // Divider start pulse, one cycle after take
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= take && (op_code == lxd_pkg::LXD_OP_DIVMOD);
        end
    end

    // Encoding length of the taken legal operation
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            instr_len_q <= '0;
        end else if (take && legal) begin
            if (op_code == lxd_pkg::LXD_OP_DIVMOD) begin
                instr_len_q <= lxd_pkg::LEN_DIVMOD;
            end else begin
                instr_len_q <= op_src_imm ? lxd_pkg::LEN_IMM : lxd_pkg::LEN_ACC; // [RQ8]
            end
        end
    end

    // ------------------------------------------------------------
    // Operand latches
    // ------------------------------------------------------------

    // Capture operands when a legal operation is taken
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            opa_q  <= lxd_pkg::ACC_RST;
            opb_q  <= lxd_pkg::ACC_RST;
            dst_q  <= lxd_pkg::ACC_X;
            src_q  <= lxd_pkg::ACC_X;
            xnor_q <= 1'b0;
        end else if (take && legal) begin
            opa_q  <= acc_q[op_dst_sel]; // [RQ6]
            dst_q  <= op_dst_sel;
            src_q  <= op_src_sel;
            xnor_q <= (op_code == lxd_pkg::LXD_OP_XNOR);
            if (op_src_imm && (op_code != lxd_pkg::LXD_OP_DIVMOD)) begin
                opb_q <= op_imm; // [RQ4] [RQ6]
            end else begin
                opb_q <= acc_q[op_src_sel]; // [RQ6]
            end
        end
    end

    // ------------------------------------------------------------
    // Accumulator file
    // ------------------------------------------------------------

    // Write-back; quotient wins if both operands name one accumulator
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < lxd_pkg::ACC_NUM; i++) begin
                acc_q[i] <= lxd_pkg::ACC_RST;
            end
        end else if (logic_wr) begin
            acc_q[dst_q] <= logic_res; // [RQ3] [RQ4] [RQ5] [RQ11]
        end else if (div_wr) begin
            acc_q[src_q] <= div_rem; // [RQ2]
            acc_q[dst_q] <= div_quot; // [RQ1]
        end else if (op_ready && acc_wr_en) begin
            acc_q[acc_wr_sel] <= acc_wr_data;
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------

    // Flag source: logic result or quotient
    assign flag_src = logic_wr ? logic_res : div_quot;

    // Sign and nonzero from the first operand's new value
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_sign_q <= lxd_pkg::FLAG_RST;
            flag_nz_q   <= lxd_pkg::FLAG_RST;
        end else if (logic_wr || div_wr) begin
            flag_sign_q <= flag_src[DATA_W-1]; // [RQ7] [RQ10]
            flag_nz_q   <= (flag_src != '0); // [RQ7] [RQ10]
        end
    end

    // Carry and overflow only from other units while idle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_carry_q <= lxd_pkg::FLAG_RST;
            flag_ovf_q   <= lxd_pkg::FLAG_RST;
        end else if (op_ready && flag_wr_en) begin
            flag_carry_q <= flag_carry_in; // [RQ7]
            flag_ovf_q   <= flag_ovf_in; // [RQ7]
        end
    end

endmodule

`default_nettype wire

// ### lxd_exec_assertions.sv
// Concurrent checks on the ports of the logic and modulo-division datapath
`timescale 1ns/10ps
`default_nettype none

module lxd_exec_assertions (
    input wire logic        clk,          // Core clock
    input wire logic        sys_rst,      // Async reset
    input wire logic        op_valid,     // Offer
    input wire logic        op_ready,     // Idle
    input wire logic [1:0]  op_code,      // Operation
    input wire logic [1:0]  op_dst_sel,   // First operand
    input wire logic        op_src_imm,   // Immediate form
    input wire logic [2:0]  instr_len_q,  // Length
    input wire logic        op_done,      // Write-back
    input wire logic        div_start,    // Divider start
    input wire logic        flag_wr_en,   // Flag load
    input wire logic [23:0] acc_x_q,      // Acc x
    input wire logic [23:0] acc_y_q,      // Acc y
    input wire logic [23:0] acc_z_q,      // Acc z
    input wire logic [23:0] acc_r_q,      // Acc r
    input wire logic        flag_sign_q,  // Sign
    input wire logic        flag_nz_q,    // Nonzero
    input wire logic        flag_carry_q, // Carry
    input wire logic        flag_ovf_q    // Overflow
);
    logic [1:0]  dst_q;
    logic [23:0] res;
    wire         take = op_valid && op_ready;
    wire         lgc  = take && !op_code[1];

    // ------------------------------------------------------------
    // Helper: first operand of the running operation
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) dst_q <= 2'h0;
        else if (take) dst_q <= op_dst_sel;
    end
    assign res = (dst_q == 2'h0) ? acc_x_q : (dst_q == 2'h1) ? acc_y_q : (dst_q == 2'h2) ? acc_z_q : acc_r_q;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_len_acc;
        take && (op_code == 2'h2 || (!op_code[1] && !op_src_imm)) |=> instr_len_q == 3'h2;
    endproperty
    a_len_acc: assert property (p_len_acc) else $error("short length wrong");
    property p_len_imm;
        lgc && op_src_imm |=> instr_len_q == 3'h5;
    endproperty
    a_len_imm: assert property (p_len_imm) else $error("long length wrong");
    property p_len_hold;
        !take |=> $stable(instr_len_q);
    endproperty
    a_len_hold: assert property (p_len_hold) else $error("length moved");
    property p_cyc_acc;
        lgc && !op_src_imm |=> !op_ready ##1 (op_done && !op_ready) ##1 op_ready;
    endproperty
    a_cyc_acc: assert property (p_cyc_acc) else $error("short op timing wrong");
    property p_cyc_imm;
        lgc && op_src_imm |=> !op_ready [*4] ##1 (op_done && !op_ready) ##1 op_ready;
    endproperty
    a_cyc_imm: assert property (p_cyc_imm) else $error("long op timing wrong");
    property p_cv_keep;
        !(flag_wr_en && op_ready) |=> $stable(flag_carry_q) && $stable(flag_ovf_q);
    endproperty
    a_cv_keep: assert property (p_cv_keep) else $error("carry or overflow moved");
    property p_flags;
        op_done |=> flag_sign_q == res[23] && flag_nz_q == (res != 24'h0);
    endproperty
    a_flags: assert property (p_flags) else $error("sign or nonzero wrong");
    property p_div_start;
        take && op_code == 2'h2 |=> div_start ##1 !div_start;
    endproperty
    a_div_start: assert property (p_div_start) else $error("divider start wrong");
endmodule

bind lxd_exec lxd_exec_assertions i_chk (.*);

`default_nettype wire

// ### lxd_exec_bench.sv
// Self-checking bench for the logic and modulo-division datapath
`timescale 1ns/10ps
`default_nettype none

module lxd_exec_bench;
    logic        clk, sys_rst, op_valid, op_ready, op_src_imm, op_done, div_start, div_done;
    logic        acc_wr_en, flag_wr_en, flag_carry_in, flag_ovf_in;
    logic        flag_sign_q, flag_nz_q, flag_carry_q, flag_ovf_q;
    logic [1:0]  op_code, op_dst_sel, op_src_sel, acc_wr_sel;
    logic [2:0]  instr_len_q;
    logic [23:0] op_imm, div_dividend, div_divisor, div_quot, div_rem, acc_wr_data;
    logic [23:0] acc_x_q, acc_y_q, acc_z_q, acc_r_q;
    int          n_mismatch, total_checks;

    lxd_exec i_dut (.*);

    // Clock, 25 ns period
    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ld(input logic [1:0] s, input logic [23:0] v);
        @(posedge clk);
        acc_wr_en <= 1'h1;
        acc_wr_sel <= s;
        acc_wr_data <= v;
        @(posedge clk);
        acc_wr_en <= 1'h0;
    endtask
    task automatic fl(input logic c, input logic o);
        @(posedge clk);
        flag_wr_en <= 1'h1;
        flag_carry_in <= c;
        flag_ovf_in <= o;
        @(posedge clk);
        flag_wr_en <= 1'h0;
    endtask
    // One operation; divider answers two cycles after the take
    task automatic op(input logic [1:0] c, input logic [1:0] d, input logic [1:0] s, input logic im,
                      input logic [23:0] v);
        int n;
        n = 0;
        @(posedge clk);
        op_valid <= 1'h1;
        op_code <= c;
        op_dst_sel <= d;
        op_src_sel <= s;
        op_src_imm <= im;
        op_imm <= v;
        @(posedge clk);
        op_valid <= 1'h0;
        if (c == 2'h2) begin
            repeat (2) @(posedge clk);
            div_done <= 1'h1;
        end
        @(negedge clk);
        while (op_done !== 1'h1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) chk("op_done", 24'h1, 24'h0);
        @(posedge clk);
        div_done <= 1'h0;
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_logic;
        ld(2'h0, 24'h00F0F0);
        ld(2'h1, 24'h0FF00F);
        op(2'h0, 2'h0, 2'h1, 1'h0, 24'h0);
        chk("acc_x", 24'h0F00FF, acc_x_q);
        chk("acc_y", 24'h0FF00F, acc_y_q);
        chk("len", 24'h2, 24'(instr_len_q));
        op(2'h1, 2'h1, 2'h0, 1'h0, 24'h0);
        chk("acc_y", 24'hFF0F0F, acc_y_q);
        chk("sign", 24'h1, 24'(flag_sign_q));
    endtask
    task automatic t_imm;
        ld(2'h3, 24'h123456);
        op(2'h0, 2'h3, 2'h0, 1'h1, 24'h123456);
        chk("acc_r", 24'h0, acc_r_q);
        chk("nz", 24'h0, 24'(flag_nz_q));
        chk("len", 24'h5, 24'(instr_len_q));
        op(2'h1, 2'h2, 2'h3, 1'h1, 24'h800000);
        chk("acc_z", 24'h7FFFFF, acc_z_q);
        chk("acc_r", 24'h0, acc_r_q);
        chk("nz", 24'h1, 24'(flag_nz_q));
    endtask
    task automatic t_flags;
        fl(1'h1, 1'h1);
        op(2'h0, 2'h0, 2'h0, 1'h0, 24'h0);
        chk("acc_x", 24'h0, acc_x_q);
        chk("carry", 24'h1, 24'(flag_carry_q));
        chk("ovf", 24'h1, 24'(flag_ovf_q));
    endtask
    task automatic t_div;
        ld(2'h1, 24'h00000B);
        ld(2'h2, 24'hFFFFFC);
        div_quot <= 24'hFFFFFD;
        div_rem <= 24'h000002;
        op(2'h2, 2'h1, 2'h2, 1'h0, 24'h0);
        chk("acc_y", 24'hFFFFFD, acc_y_q);
        chk("acc_z", 24'h000002, acc_z_q);
        chk("dividend", 24'h00000B, div_dividend);
        chk("divisor", 24'hFFFFFC, div_divisor);
        chk("sign", 24'h1, 24'(flag_sign_q));
    endtask
    // Code 11 changes nothing; side writes are refused while busy
    task automatic t_refuse;
        @(posedge clk);
        op_valid <= 1'h1;
        op_code <= 2'h3;
        op_dst_sel <= 2'h1;
        op_src_sel <= 2'h0;
        op_src_imm <= 1'h1;
        op_imm <= 24'h00000F;
        @(posedge clk);
        op_valid <= 1'h0;
        @(negedge clk);
        chk("nop ready", 24'h1, 24'(op_ready));
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk("nop acc_y", 24'hFFFFFD, acc_y_q);
        chk("nop len", 24'h2, 24'(instr_len_q));
        @(posedge clk);
        op_valid <= 1'h1;
        op_code <= 2'h0;
        @(posedge clk);
        op_valid <= 1'h0;
        acc_wr_en <= 1'h1;
        acc_wr_sel <= 2'h0;
        acc_wr_data <= 24'h5A5A5A;
        flag_wr_en <= 1'h1;
        flag_carry_in <= 1'h0;
        flag_ovf_in <= 1'h0;
        @(posedge clk);
        acc_wr_en <= 1'h0;
        flag_wr_en <= 1'h0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("busy acc_y", 24'hFFFFF2, acc_y_q);
        chk("busy acc_x", 24'h0, acc_x_q);
        chk("busy carry", 24'h1, 24'(flag_carry_q));
        chk("busy ovf", 24'h1, 24'(flag_ovf_q));
    endtask

    // Main sequence
    initial begin
        clk = 1'h0;
        sys_rst = 1'h1;
        {op_valid, op_code, op_dst_sel, op_src_sel, op_src_imm, op_imm, div_done} = '0;
        {div_quot, div_rem, acc_wr_en, acc_wr_sel, acc_wr_data} = '0;
        {flag_wr_en, flag_carry_in, flag_ovf_in} = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        chk("reset acc_x", 24'h0, acc_x_q);
        t_logic;
        t_imm;
        t_flags;
        t_div;
        t_refuse;
        end_of_test;
    end

    // Watchdog
    initial begin
        #20000;
        n_mismatch++;
        end_of_test;
    end
endmodule

`default_nettype wire

// ### lxd_pkg.sv
// Constants and types for the logic and modulo-division execution datapath
package lxd_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W  = 24;
    localparam int unsigned ACC_NUM = 4;
    localparam int unsigned SEL_W   = 2;
    localparam int unsigned CNT_W   = 3;
    localparam int unsigned LEN_W   = 3;

    // ------------------------------------------------------------
    // Accumulator selects
    // ------------------------------------------------------------
    localparam logic [1:0] ACC_X = 2'h0;
    localparam logic [1:0] ACC_Y = 2'h1;
    localparam logic [1:0] ACC_Z = 2'h2;
    localparam logic [1:0] ACC_R = 2'h3;

    // ------------------------------------------------------------
    // Operation codes from the decoder
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LXD_OP_XOR    = 2'b00,
        LXD_OP_XNOR   = 2'b01,
        LXD_OP_DIVMOD = 2'b10
    } lxd_op_t;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LXD_ST_IDLE  = 2'b00,
        LXD_ST_LOGIC = 2'b01,
        LXD_ST_DIVW  = 2'b10
    } lxd_state_t;

    // ------------------------------------------------------------
    // Encoding lengths in bytes and cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] LEN_ACC    = 3'h2;
    localparam logic [2:0] LEN_IMM    = 3'h5;
    localparam logic [2:0] LEN_DIVMOD = 3'h2;
    localparam logic [2:0] CYC_ACC    = 3'h3;
    localparam logic [2:0] CYC_IMM    = 3'h6;
    localparam logic [2:0] CNT_LAST   = 3'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [23:0] ACC_RST  = 24'h000000;
    localparam logic        FLAG_RST = 1'b0;

endpackage
